// >>> inc/acc_pkg.sv
// Shared constants and types of the converter control block
`default_nettype none
package acc_pkg;
    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_PORT_A  = 8'h05;
    localparam logic [7:0] ADDR_GLOBAL_INTERRUPT_CONTROL  = 8'h0B;
    localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_ONE    = 8'h0C;
    localparam logic [7:0] ADDR_RESULT  = 8'h1E;
    localparam logic [7:0] ADDR_CTRL0   = 8'h1F;
    localparam logic [7:0] ADDR_PIN_DIRECTION_BIT    = 8'h85;
    localparam logic [7:0] ADDR_PERIPHERAL_ENABLES_ONE    = 8'h8C;
    localparam logic [7:0] ADDR_CFG1    = 8'h9F;
    // ************************************************************
    // Reset values and field positions
    // ************************************************************
    localparam logic [7:0] RST_CTRL0    = 8'h00;
    localparam logic [5:0] RST_PIN_DIRECTION_BIT     = 6'h3F;
    localparam logic [5:0] RST_PORT_OUT = 6'h00;
    localparam logic [7:0] RST_GLOBAL_INTERRUPT_CONTROL   = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_FLAGS_ONE     = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_ENABLES_ONE     = 8'h00;
    localparam logic [2:0] RST_CFG1     = 3'h0;
    localparam int         DONE_BIT     = 6;
    localparam logic [7:0] PIR_MASK     = 8'h4F;
    // ************************************************************
    // Modes, channel map and timing
    // ************************************************************
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    localparam int         NUM_CH       = 5;
    localparam logic [5:0] ANA_ALL      = 6'h2F;
    localparam logic [5:0] ANA_FEW      = 6'h0B;
    localparam logic [5:0] ANA_NONE     = 6'h00;
    localparam int         CLK_HZ       = 40000000;
    localparam int         RC_TAD_NS    = 4000;
    localparam int         RC_MIN_NS    = 2000;
    localparam int         RC_MAX_NS    = 6000;
    localparam int         RC_HALF_CYC  = (RC_TAD_NS / 2) * (CLK_HZ / 1000000) / 1000;
    localparam int         HALF_DIV2    = 1;
    localparam int         HALF_DIV8    = 4;
    localparam int         HALF_DIV32   = 16;
    localparam logic [4:0] CONV_HALVES  = 5'h13;
    typedef enum logic [1:0] {
        ACC_CS_DIV2  = 2'b00,
        ACC_CS_DIV8  = 2'b01,
        ACC_CS_DIV32 = 2'b10,
        ACC_CS_RC    = 2'b11
    } acc_clk_sel_t;
    typedef enum logic {
        ACC_IDLE = 1'b0,
        ACC_CONV = 1'b1
    } acc_state_t;
    typedef struct packed {
        acc_clk_sel_t cs;
        logic [2:0]   ch;
        logic         go;
        logic         rsv;
        logic         on;
    } acc_ctrl0_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acc_bus_req_t;
endpackage
`default_nettype wire

// >>> src/acc_adc_ctrl.sv
// Conversion control, timing and registers of the 8-bit converter
`default_nettype none
// Overview of operation
// - Full 8-bit result takes nine and half periods
// - Clock select gives 2, 8, 32 Tosc or RC
// - RC bit period typically 4 us, 2 to 6
// - Analog pins read back as zero
// - Selected pin converted whatever its direction
// - Compare trigger starts conversion, clears timer
// - Trigger ignored when off, timer still cleared
// - Completion loads result, clears start, sets flag
// - Channel codes 0 to 4; reset aborts
module acc_adc_ctrl (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Register port
    input  wire acc_pkg::acc_bus_req_t bus_req,
    output logic [7:0]                rdata,
    // Core state
    input  wire logic                 sleep_mode,
    // Compare unit
    input  wire logic [3:0]           cmp_mode,
    input  wire logic                 cmp_event,
    output logic                      timer_clear,
    // Port A pins
    input  wire logic [5:0]           pin_in,
    output logic [5:0]                pin_out,
    output logic [5:0]                pin_oe_n,
    // Analog front end
    output logic [4:0]                ch_onehot,
    output logic                      sample_hold,
    output logic [7:0]                sar_trial,
    input  wire logic                 cmp_above,
    // Interrupt
    output logic                      irq
);
    // ************************************************************
    // Registers
    // ************************************************************
    acc_pkg::acc_ctrl0_t  ctrl_r;
    acc_pkg::acc_state_t  state_r;
    acc_pkg::acc_clk_sel_t cs_run_r;
    logic [5:0]           pin_direction_bit_r;
    logic [5:0]           port_out_r;
    logic [7:0]           global_interrupt_control_r;
    logic [7:0]           pir_r;
    logic [7:0]           pie_r;
    logic [2:0]           cfg_r;
    logic [7:0]           result_r;
    logic [7:0]           trial_r;
    logic [2:0]           bit_idx_r;
    logic [4:0]           half_cnt_r;
    logic [6:0]           div_cnt_r;
    logic [7:0]           rdata_r;
    logic                 timer_clear_r;
    logic                 hold_r;
    logic                 irq_r;
    // ************************************************************
    // Decode and control terms
    // ************************************************************
    logic       wr_ctrl;
    logic       trig_special;
    logic       start_req;
    logic       abort_req;
    logic       tick_en;
    logic       half_tick;
    logic       done_pulse;
    logic       decide;
    logic [6:0] half_len;
    logic [5:0] ana_mask;
    logic [7:0] rd_mux;

    assign wr_ctrl      = bus_req.wr && (bus_req.addr == acc_pkg::ADDR_CTRL0);
    assign trig_special = cmp_event && (cmp_mode == acc_pkg::MODE_SPECIAL);
    // Start needs the converter already on; a write that turns it on cannot start
    assign start_req    = (state_r == acc_pkg::ACC_IDLE) && ctrl_r.on &&
                          ((wr_ctrl && bus_req.wdata[2]) || trig_special);
    assign abort_req    = (state_r == acc_pkg::ACC_CONV) && wr_ctrl &&
                          (!bus_req.wdata[0] || !bus_req.wdata[2]);
    // Oscillator stops in sleep; only the RC source keeps running
    assign tick_en      = !sleep_mode || (cs_run_r == acc_pkg::ACC_CS_RC);
    assign half_tick    = (state_r == acc_pkg::ACC_CONV) && tick_en &&
                          (div_cnt_r == half_len - 7'h01);
    assign done_pulse   = half_tick && (half_cnt_r == acc_pkg::CONV_HALVES - 5'h01) &&
                          !abort_req;
    assign decide       = half_tick && half_cnt_r[0] == 1'b0 && half_cnt_r >= 5'h02 &&
                          half_cnt_r <= 5'h10;

    // Half bit period length per clock source
    always_comb begin
        case (cs_run_r)
            acc_pkg::ACC_CS_DIV2:  half_len = 7'(acc_pkg::HALF_DIV2);
            acc_pkg::ACC_CS_DIV8:  half_len = 7'(acc_pkg::HALF_DIV8);
            acc_pkg::ACC_CS_DIV32: half_len = 7'(acc_pkg::HALF_DIV32);
            acc_pkg::ACC_CS_RC:    half_len = 7'(acc_pkg::RC_HALF_CYC);
            default:               half_len = 7'(acc_pkg::HALF_DIV2);
        endcase
    end

    // Analog pins per configuration code
    always_comb begin
        case (cfg_r[2:1])
            2'h0, 2'h1: ana_mask = acc_pkg::ANA_ALL;
            2'h2:       ana_mask = acc_pkg::ANA_FEW;
            2'h3:       ana_mask = acc_pkg::ANA_NONE;
            default:    ana_mask = acc_pkg::ANA_NONE;
        endcase
    end

    // ************************************************************
    // Control register and conversion state
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r   <= acc_pkg::RST_CTRL0;
            state_r  <= acc_pkg::ACC_IDLE;
            cs_run_r <= acc_pkg::ACC_CS_DIV2;
        end else begin
            if (wr_ctrl) begin
                ctrl_r.cs <= acc_pkg::acc_clk_sel_t'(bus_req.wdata[7:6]);
                ctrl_r.ch <= bus_req.wdata[5:3];
                ctrl_r.on <= bus_req.wdata[0];
            end
            if (start_req) begin
                state_r  <= acc_pkg::ACC_CONV;
                ctrl_r.go <= 1'b1;
                cs_run_r <= wr_ctrl ? acc_pkg::acc_clk_sel_t'(bus_req.wdata[7:6]) : ctrl_r.cs;
            end else if (done_pulse || abort_req) begin
                state_r  <= acc_pkg::ACC_IDLE;
                ctrl_r.go <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Half period divider and counter
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn || start_req) begin
            div_cnt_r  <= 7'h00;
            half_cnt_r <= 5'h00;
        end else if (half_tick) begin
            div_cnt_r  <= 7'h00;
            half_cnt_r <= half_cnt_r + 5'h01;
        end else if (state_r == acc_pkg::ACC_CONV && tick_en) begin
            div_cnt_r  <= div_cnt_r + 7'h01;
        end
    end

    // ************************************************************
    // Successive approximation
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn || start_req) begin
            trial_r   <= 8'h80;
            bit_idx_r <= 3'h7;
        end else if (decide) begin
            trial_r[bit_idx_r] <= cmp_above;
            if (bit_idx_r != 3'h0) begin
                trial_r[bit_idx_r - 3'h1] <= 1'b1;
            end
            bit_idx_r <= bit_idx_r - 3'h1;
        end
    end

    // Result has no reset and moves only on completion
    always_ff @(posedge clk) begin
        if (done_pulse) begin
            result_r <= trial_r;
        end
    end

    // ************************************************************
    // Channel select and pin side
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < acc_pkg::NUM_CH; gi++) begin : g_ch
            // Direction bits play no part in the selection
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    ch_onehot[gi] <= 1'b0;
                end else begin
                    ch_onehot[gi] <= ctrl_r.on && (ctrl_r.ch == 3'(gi));
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_direction_bit_r     <= acc_pkg::RST_PIN_DIRECTION_BIT;
            port_out_r <= acc_pkg::RST_PORT_OUT;
            cfg_r      <= acc_pkg::RST_CFG1;
        end else if (bus_req.wr) begin
            if (bus_req.addr == acc_pkg::ADDR_PIN_DIRECTION_BIT) pin_direction_bit_r <= bus_req.wdata[5:0];
            if (bus_req.addr == acc_pkg::ADDR_PORT_A) port_out_r <= bus_req.wdata[5:0];
            if (bus_req.addr == acc_pkg::ADDR_CFG1) cfg_r <= bus_req.wdata[2:0];
        end
    end

    // ************************************************************
    // Interrupt flags
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pir_r    <= acc_pkg::RST_PERIPHERAL_FLAGS_ONE;
            pie_r    <= acc_pkg::RST_PERIPHERAL_ENABLES_ONE;
            global_interrupt_control_r <= acc_pkg::RST_GLOBAL_INTERRUPT_CONTROL;
            irq_r    <= 1'b0;
        end else begin
            if (bus_req.wr && bus_req.addr == acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE) begin
                pir_r <= pir_r & ~bus_req.wdata;
            end
            if (done_pulse) begin
                pir_r[acc_pkg::DONE_BIT] <= 1'b1;
            end
            if (bus_req.wr && bus_req.addr == acc_pkg::ADDR_PERIPHERAL_ENABLES_ONE) begin
                pie_r <= bus_req.wdata & acc_pkg::PIR_MASK;
            end
            if (bus_req.wr && bus_req.addr == acc_pkg::ADDR_GLOBAL_INTERRUPT_CONTROL) begin
                global_interrupt_control_r <= bus_req.wdata;
            end
            irq_r <= |(pir_r & pie_r);
        end
    end

    // ************************************************************
    // Trigger side effects and analog outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer_clear_r <= 1'b0;
            hold_r        <= 1'b0;
        end else begin
            timer_clear_r <= trig_special;
            hold_r        <= start_req || (state_r == acc_pkg::ACC_CONV &&
                             !done_pulse && !abort_req);
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_comb begin
        case (bus_req.addr)
            acc_pkg::ADDR_PORT_A: rd_mux = {2'h0, pin_in & ~ana_mask};
            acc_pkg::ADDR_GLOBAL_INTERRUPT_CONTROL: rd_mux = global_interrupt_control_r;
            acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE:   rd_mux = pir_r;
            acc_pkg::ADDR_RESULT: rd_mux = result_r;
            acc_pkg::ADDR_CTRL0:  rd_mux = {ctrl_r.cs, ctrl_r.ch, ctrl_r.go, 1'b0, ctrl_r.on};
            acc_pkg::ADDR_PIN_DIRECTION_BIT:   rd_mux = {2'h0, pin_direction_bit_r};
            acc_pkg::ADDR_PERIPHERAL_ENABLES_ONE:   rd_mux = pie_r;
            acc_pkg::ADDR_CFG1:   rd_mux = {5'h00, cfg_r};
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    assign rdata       = rdata_r;
    assign timer_clear = timer_clear_r;
    assign pin_out     = port_out_r;
    assign pin_oe_n    = pin_direction_bit_r;
    assign sample_hold = hold_r;
    assign sar_trial   = trial_r;
    assign irq         = irq_r;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [10:0] conv_cyc_r;
    logic [6:0]  gap_r;
    logic [10:0] conv_len;
    logic        res_loaded_r;
    assign conv_len = 11'(half_len) * 11'(acc_pkg::CONV_HALVES);

    always_ff @(posedge clk) begin
        if (!resetn || start_req) begin
            conv_cyc_r <= 11'h000;
            gap_r      <= 7'h00;
        end else if (state_r == acc_pkg::ACC_CONV) begin
            conv_cyc_r <= conv_cyc_r + 11'h001;
            gap_r      <= half_tick ? 7'h00 : gap_r + 7'h01;
        end
    end

    // Result unknown until a first completion
    always_ff @(posedge clk) begin
        if (!resetn) begin
            res_loaded_r <= 1'b0;
        end else if (done_pulse) begin
            res_loaded_r <= 1'b1;
        end
    end

    sequence s_trig_on;
        trig_special && ctrl_r.on && state_r == acc_pkg::ACC_IDLE;
    endsequence
    sequence s_started;
        state_r == acc_pkg::ACC_CONV && ctrl_r.go && timer_clear;
    endsequence

    a_conv_length: assert property (@(posedge clk) disable iff (!resetn)
        done_pulse && !sleep_mode |-> conv_cyc_r + 11'h001 == conv_len)
        else $error("conversion length differs from nineteen half periods");
    a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
        half_tick && tick_en && !sleep_mode |-> gap_r + 7'h01 == half_len)
        else $error("half period spacing wrong for clock select");
    a_rc_span: assert property (@(posedge clk) disable iff (!resetn)
        half_tick && cs_run_r == acc_pkg::ACC_CS_RC |->
        gap_r >= 7'h27 && gap_r <= 7'h77)
        else $error("RC bit period outside 2 to 6 us");
    a_trig_start: assert property (@(posedge clk) disable iff (!resetn)
        s_trig_on |=> s_started)
        else $error("special trigger did not start conversion");
    a_trig_ignored: assert property (@(posedge clk) disable iff (!resetn)
        trig_special && !ctrl_r.on && state_r == acc_pkg::ACC_IDLE |=>
        state_r == acc_pkg::ACC_IDLE && timer_clear)
        else $error("trigger not ignored while converter off");
    a_done_effects: assert property (@(posedge clk) disable iff (!resetn)
        done_pulse |=> !ctrl_r.go && pir_r[acc_pkg::DONE_BIT] &&
        result_r == $past(trial_r) ##1 irq == pie_r[acc_pkg::DONE_BIT])
        else $error("completion effects missing");
    a_result_hold: assert property (@(posedge clk) disable iff (!resetn)
        res_loaded_r && !done_pulse |=> $stable(result_r))
        else $error("result changed without completion");
    a_port_analog: assert property (@(posedge clk) disable iff (!resetn)
        bus_req.rd && bus_req.addr == acc_pkg::ADDR_PORT_A |=>
        (rdata[5:0] & $past(ana_mask)) == 6'h00)
        else $error("analog pin read back nonzero");
    a_chan_decode: assert property (@(posedge clk) disable iff (!resetn)
        ctrl_r.on && ctrl_r.ch <= 3'h4 && $stable(ctrl_r) |=>
        ch_onehot == 5'(5'h01 << $past(ctrl_r.ch)))
        else $error("channel select decode wrong");
endmodule
`default_nettype wire

// >>> dv/acc_far_side.sv
// Model of the analog pins and port levels that face the converter
`default_nettype none
module acc_far_side (
    // Converter side
    input  wire logic [4:0]      ch_onehot,
    input  wire logic [7:0]      sar_trial,
    output logic                 cmp_above,
    // Port A pins
    input  wire logic [5:0]      pin_out,
    input  wire logic [5:0]      pin_oe_n,
    output logic [5:0]           pin_in,
    // Levels chosen by the bench
    input  wire logic [4:0][7:0] lvl,
    input  wire logic [5:0]      dig
);
    timeunit 1ns;
    timeprecision 1ps;
    int         p;
    logic [7:0] sel;
    always_comb begin
        sel = 8'h00;
        p = 0;
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = pin_oe_n[i] ? dig[i] : pin_out[i];
        end
        // No channel selected: answer is the parity of the trial code
        cmp_above = ^sar_trial;
        for (int c = 0; c < 5; c++) begin
            if (ch_onehot[c]) begin
                p = (c == 4) ? 5 : c;
                sel = pin_oe_n[p] ? lvl[c] : {8{pin_out[p]}};
                cmp_above = (sel >= sar_trial);
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/acc_adc_ctrl_tb_top.sv
// Self-checking bench of the converter control block
`default_nettype none
module acc_adc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk;
    logic                  resetn;
    acc_pkg::acc_bus_req_t bus_req;
    logic [7:0]            rdata;
    logic                  sleep_mode;
    logic [3:0]            cmp_mode;
    logic                  cmp_event;
    logic                  timer_clear;
    logic [5:0]            pin_in, pin_out, pin_oe_n, dig;
    logic [4:0]            ch_onehot;
    logic                  sample_hold;
    logic [7:0]            sar_trial, v;
    logic                  cmp_above;
    logic                  irq;
    logic [4:0][7:0]       lvl;
    logic                  rd_seen;
    logic [15:0]           rd_q[$];
    logic [15:0]           conv_q[$];
    logic [2:0]            ch;
    int                    fails, comparisons, tc_cnt, sh_cnt;
    // ************************************************************
    // Clock, instances, monitor
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    acc_adc_ctrl acc_adc_ctrl_i (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
        .sleep_mode(sleep_mode), .cmp_mode(cmp_mode), .cmp_event(cmp_event),
        .timer_clear(timer_clear), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ch_onehot(ch_onehot), .sample_hold(sample_hold), .sar_trial(sar_trial),
        .cmp_above(cmp_above), .irq(irq));
    acc_far_side acc_far_side_i (.ch_onehot(ch_onehot), .sar_trial(sar_trial),
        .cmp_above(cmp_above), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
        .lvl(lvl), .dig(dig));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    always @(posedge clk) rd_seen <= bus_req.rd;
    always @(negedge clk) begin
        if (timer_clear === 1'b1) tc_cnt++;
        if (rd_seen === 1'b1 && rd_q.size() > 0) chk("rdata", rd_q.pop_front(), {8'h00, rdata});
        if (sample_hold === 1'b1) sh_cnt++;
        else if (sh_cnt != 0) begin
            if (conv_q.size() > 0) chk("conversion cycles", conv_q.pop_front(), 16'(sh_cnt));
            sh_cnt = 0;
        end
    end
    // ************************************************************
    // Bus and stimulus tasks
    // ************************************************************
    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back({8'h00, e});
        bus(a, 8'h00, 1'b0);
    endtask
    task automatic pulse();
        @(posedge clk);
        cmp_event <= 1'b1;
        @(posedge clk);
        cmp_event <= 1'b0;
    endtask
    function automatic int hv(input logic [1:0] cs);
        case (cs)
            2'b00: return acc_pkg::HALF_DIV2;
            2'b01: return acc_pkg::HALF_DIV8;
            2'b10: return acc_pkg::HALF_DIV32;
            default: return acc_pkg::RC_HALF_CYC;
        endcase
    endfunction
    task automatic conv(input logic [1:0] cs, input logic [2:0] c, input logic trig,
                        input logic ie, input logic [7:0] e);
        logic [7:0] c0;
        c0 = {cs, c, 3'b001};
        bus(acc_pkg::ADDR_PERIPHERAL_ENABLES_ONE, {1'b0, ie, 6'h00}, 1'b1);
        bus(acc_pkg::ADDR_CTRL0, c0, 1'b1);
        repeat (520) @(posedge clk);
        sleep_mode <= (cs == 2'b11);
        conv_q.push_back(16'(19 * hv(cs)));
        if (trig) pulse();
        else bus(acc_pkg::ADDR_CTRL0, c0 | 8'h04, 1'b1);
        #1 chk("channel", 16'(5'h01 << c), {11'h000, ch_onehot});
        for (int i = 0; i < 2000 && sample_hold === 1'b1; i++) @(posedge clk);
        sleep_mode <= 1'b0;
        repeat (4 * hv(cs)) @(posedge clk);
        rd(acc_pkg::ADDR_RESULT, e);
        rd(acc_pkg::ADDR_CTRL0, c0);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h40);
        #1 chk("irq", {15'h0000, ie}, {15'h0000, irq});
        bus(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h40, 1'b1);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
    endtask
    task automatic complete_run();
        $display("Counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        resetn = 1'b0;
        bus_req = '0;
        sleep_mode = 1'b0;
        cmp_mode = 4'h0;
        cmp_event = 1'b0;
        lvl = '0;
        dig = 6'h00;
        void'($urandom(56));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(acc_pkg::ADDR_CTRL0, 8'h00);
        rd(acc_pkg::ADDR_PIN_DIRECTION_BIT, 8'h3F);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
        rd(acc_pkg::ADDR_PERIPHERAL_ENABLES_ONE, 8'h00);
        rd(acc_pkg::ADDR_CFG1, 8'h00);
        rd(8'h40, 8'h00);
        $display("Test reset values done");
        dig <= 6'($urandom);
        for (int k = 0; k < 4; k++) begin
            v = {5'h00, (k == 1) ? 3'h4 : (k == 2) ? 3'h6 : 3'h0};
            bus(acc_pkg::ADDR_CFG1, v, 1'b1);
            rd(acc_pkg::ADDR_CFG1, v);
            rd(acc_pkg::ADDR_PORT_A, {2'b00, dig & ~(v[2] == 1'b0 ? acc_pkg::ANA_ALL :
                v[1] ? acc_pkg::ANA_NONE : acc_pkg::ANA_FEW)});
        end
        $display("Test port readback done");
        cmp_mode <= acc_pkg::MODE_SPECIAL;
        for (int cs = 0; cs < 4; cs++) begin
            ch = 3'($urandom % 5);
            v = 8'($urandom);
            lvl[ch] <= v;
            conv(2'(cs), ch, cs[0], cs[1], v);
        end
        chk("timer clears", 16'h0002, 16'(tc_cnt));
        $display("Test conversions done");
        bus(acc_pkg::ADDR_CTRL0, 8'h00, 1'b1);
        pulse();
        repeat (40) @(posedge clk);
        rd(acc_pkg::ADDR_CTRL0, 8'h00);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
        chk("timer clears", 16'h0003, 16'(tc_cnt));
        cmp_mode <= 4'h2;
        bus(acc_pkg::ADDR_CTRL0, 8'h01, 1'b1);
        pulse();
        repeat (40) @(posedge clk);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
        chk("timer clears", 16'h0003, 16'(tc_cnt));
        $display("Test compare trigger done");
        bus(acc_pkg::ADDR_PIN_DIRECTION_BIT, 8'h3E, 1'b1);
        bus(acc_pkg::ADDR_PORT_A, 8'h01, 1'b1);
        conv(2'b00, 3'h0, 1'b0, 1'b0, 8'hFF);
        bus(acc_pkg::ADDR_PIN_DIRECTION_BIT, 8'h3F, 1'b1);
        $display("Test driven pin conversion done");
        bus(acc_pkg::ADDR_CTRL0, 8'h81, 1'b1);
        bus(acc_pkg::ADDR_CTRL0, 8'h85, 1'b1);
        repeat (50) @(posedge clk);
        bus(acc_pkg::ADDR_CTRL0, 8'h81, 1'b1);
        rd(acc_pkg::ADDR_CTRL0, 8'h81);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
        rd(acc_pkg::ADDR_RESULT, 8'hFF);
        repeat (64) @(posedge clk);
        bus(acc_pkg::ADDR_CTRL0, 8'h85, 1'b1);
        repeat (50) @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(acc_pkg::ADDR_CTRL0, 8'h00);
        rd(acc_pkg::ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
        rd(acc_pkg::ADDR_RESULT, 8'hFF);
        repeat (2) @(posedge clk);
        $display("Test reset abort done");
        complete_run();
    end
endmodule
`default_nettype wire
